// ---- src/sice_pkg.sv ----
// Package with the constants and codes of the safety input channel evaluator.
package sice_pkg;
   // Clock and scan timing.
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned NS_PER_MS = 1000000;
   localparam int unsigned CLK_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
   localparam int unsigned SCAN_TIME_MS_DEF = 1;
   // Discrepancy time setting, held in steps of ten milliseconds.
   localparam int unsigned DISC_STEP_MS = 10;
   localparam int unsigned DISC_MAX_MS = 30000;
   localparam int unsigned DISC_DEF_MS = 30;
   localparam int unsigned DISC_W = 12;
   localparam int unsigned CNT_W = 16;
   localparam logic [DISC_W-1:0] DISC_MAX_SET =
      DISC_W'(DISC_MAX_MS / DISC_STEP_MS);
   localparam logic [DISC_W-1:0] DISC_DEF_SET =
      DISC_W'(DISC_DEF_MS / DISC_STEP_MS);
   localparam logic [DISC_W-1:0] DISC_OFF_SET = 12'h000;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
   localparam logic [31:0] SCAN_CNT_ZERO = 32'h00000000;
   localparam logic [31:0] SCAN_CNT_ONE = 32'h00000001;
   // Input type codes on the configuration port.
   localparam logic [2:0] TYPE_SINGLE = 3'h0;
   localparam logic [2:0] TYPE_DUAL_EQ = 3'h1;
   localparam logic [2:0] TYPE_DUAL_CO = 3'h2;
   localparam logic [2:0] TYPE_DUAL_EQ2 = 3'h3;
   localparam logic [2:0] TYPE_DUAL_CO2 = 3'h4;
   localparam logic [2:0] TYPE_DEF = TYPE_DUAL_EQ;
   // Block class codes, which select the startup behaviour.
   localparam logic [1:0] CLASS_MONITOR = 2'h0;
   localparam logic [1:0] CLASS_COUNT = 2'h1;
   localparam logic [1:0] CLASS_TWOHAND = 2'h2;
   localparam logic [1:0] CLASS_GATE = 2'h3;
   // Input bit positions.
   localparam int unsigned IN_CH1 = 0;
   localparam int unsigned IN_CH2 = 1;
   localparam int unsigned IN_CH3 = 2;
   localparam int unsigned IN_CH4 = 3;
   // Output arming states.
   typedef enum logic [3:0] {
      ST_STOP = 4'h1,
      ST_WAIT_OFF = 4'h2,
      ST_WAIT_ON = 4'h4,
      ST_RUN = 4'h8
   } sice_state_e;
endpackage

// ---- src/sice_pair.sv ----
// One channel pair: status decode, discrepancy timer and error flag.
`timescale 1ns/1ps
module sice_pair
   import sice_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic start_i,
   input wire logic en_i,
   input wire logic compl_i,
   input wire logic check_i,
   input wire logic a_i,
   input wire logic b_i,
   input wire logic [CNT_W-1:0] limit_i,
   output logic active_o,
   output logic inactive_o,
   output logic err_o
);
   logic [CNT_W-1:0] cnt;
   logic seen_active;
   logic err;
   wire b_ok = compl_i ? ~b_i : b_i;
   wire act_now = a_i & b_ok;
   wire inact_now = ~a_i & ~b_ok;
   wire disc_now = en_i & ~act_now & ~inact_now;
   // A timeout is only seen while the pair is still discrepant, so a valid
   // combination arriving in the same scan wins over the error.
   wire timeout = check_i & disc_now & (cnt >= limit_i);
   wire [CNT_W-1:0] next_cnt = (cnt == CNT_MAX) ? cnt : cnt + CNT_ONE;
   // The error seen outside is this scan's new value, so the discrepancy and fault
   // flags rise in the very scan that times out rather than one scan late.
   wire next_err = (start_i | ~en_i) ? 1'b0 :
                   timeout ? 1'b1 :
                   (err & seen_active & inact_now) ? 1'b0 : err;

   assign active_o = act_now;
   assign inactive_o = inact_now;
   assign err_o = next_err;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt <= CNT_ZERO;
      end else if (tick_i) begin
         if (start_i || !disc_now) begin
            cnt <= disc_now ? CNT_ONE : CNT_ZERO;
         end else begin
            cnt <= next_cnt;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         err <= 1'b0;
         seen_active <= 1'b0;
      end else if (tick_i) begin
         err <= next_err;
         if (start_i || !en_i) begin
            seen_active <= 1'b0;
         end else if (timeout) begin
            seen_active <= seen_active;
         end else if (err && act_now) begin
            seen_active <= 1'b1;
         end else if (err && seen_active && inact_now) begin
            seen_active <= 1'b0;
         end
      end
   end
endmodule

// ---- src/sice_eval.sv ----
// Safety input channel evaluator: scan timing, truth tables and startup.
`timescale 1ns/1ps
module sice_eval
   import sice_pkg::*;
#(
   parameter int unsigned SCAN_TIME_MS = SCAN_TIME_MS_DEF,
   parameter int unsigned SCAN_CLKS = SCAN_TIME_MS_DEF * CLK_PER_MS
)
(
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic RUN_I,
   input wire logic CFG_LOAD_I,
   input wire logic [2:0] CFG_TYPE_I,
   input wire logic [DISC_W-1:0] CFG_DISC_I,
   input wire logic [1:0] CLASS_I,
   input wire logic FUNC_TEST_I,
   input wire logic [3:0] IN_I,
   output logic PERMIT_O,
   output logic DISC_ERR_O,
   output logic FAULT_O,
   output logic COUNT_O,
   output logic ACTIVE_O,
   output logic ARMED_O,
   output logic CFG_ERR_O,
   output logic SCAN_O
);
   logic [31:0] scan_cnt;
   logic [2:0] in_type;
   logic [DISC_W-1:0] disc_set;
   logic running;
   logic prev_active;
   logic permit;
   logic disc_err;
   logic fault;
   logic count_pulse;
   logic cfg_err;
   sice_state_e state;
   sice_state_e next_state;
   logic p0_act;
   logic p0_inact;
   logic p0_err;
   logic p1_act;
   logic p1_inact;
   logic p1_err;

   // Scan cycle tick: all evaluation happens on this one-clock strobe.
   wire scan_end = (scan_cnt == 32'(SCAN_CLKS - 1));
   wire tick = scan_end;
   // Start of operation is the first scan that sees the run request.
   wire start = tick & RUN_I & ~running;

   // Input type decode.
   wire ty_single = (in_type == TYPE_SINGLE);
   wire ty_co = (in_type == TYPE_DUAL_CO) || (in_type == TYPE_DUAL_CO2);
   wire ty_two = (in_type == TYPE_DUAL_EQ2) || (in_type == TYPE_DUAL_CO2);
   wire type_ok = (CFG_TYPE_I == TYPE_SINGLE) ||
                  (CFG_TYPE_I == TYPE_DUAL_EQ) ||
                  (CFG_TYPE_I == TYPE_DUAL_CO) ||
                  (CFG_TYPE_I == TYPE_DUAL_EQ2) ||
                  (CFG_TYPE_I == TYPE_DUAL_CO2);
   wire disc_ok = (CFG_DISC_I <= DISC_MAX_SET);
   wire cfg_ok = type_ok & disc_ok;

   // Discrepancy time in scans: the error fires on the first scan whose
   // elapsed time strictly exceeds the setting, which lands the effect in
   // the window between that multiple and one scan later.
   wire [31:0] disc_ms = 32'(disc_set) * DISC_STEP_MS;
   wire [CNT_W-1:0] disc_limit =
      CNT_W'(disc_ms / SCAN_TIME_MS + 1);
   wire disc_check = (disc_set != DISC_OFF_SET);

   // Evaluated input status per type.
   wire single_act = IN_I[IN_CH1];
   wire pair_act = ty_two ? (p0_act & p1_act) : p0_act;
   wire eval_active = ty_single ? single_act : pair_act;
   wire eval_inactive = ty_single ? ~IN_I[IN_CH1] :
                        (ty_two ? (p0_inact & p1_inact) : p0_inact);
   wire any_err = p0_err | p1_err;
   wire rise = eval_active & ~prev_active;

   // Class decode for the startup behaviour.
   wire cls_count = (CLASS_I == CLASS_COUNT);
   wire cls_hand = (CLASS_I == CLASS_TWOHAND);
   wire cls_gate = (CLASS_I == CLASS_GATE);
   wire need_edge = cls_hand | (cls_gate & FUNC_TEST_I);
   wire next_permit = running & RUN_I & (next_state == ST_RUN) &
                      eval_active & ~any_err;

   sice_pair u_pair0 (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .tick_i(tick),
      .start_i(start),
      .en_i(~ty_single),
      .compl_i(ty_co),
      .check_i(disc_check),
      .a_i(IN_I[IN_CH1]),
      .b_i(IN_I[IN_CH2]),
      .limit_i(disc_limit),
      .active_o(p0_act),
      .inactive_o(p0_inact),
      .err_o(p0_err)
   );

   sice_pair u_pair1 (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .tick_i(tick),
      .start_i(start),
      .en_i(ty_two),
      .compl_i(ty_co),
      .check_i(disc_check),
      .a_i(IN_I[IN_CH3]),
      .b_i(IN_I[IN_CH4]),
      .limit_i(disc_limit),
      .active_o(p1_act),
      .inactive_o(p1_inact),
      .err_o(p1_err)
   );

   // Arming state machine; the next state is the one the permit obeys.
   always_comb begin
      next_state = state;
      case (state)
         ST_STOP: begin
            if (start) begin
               if (!need_edge) begin
                  next_state = ST_RUN;
               end else if (eval_active) begin
                  next_state = ST_WAIT_OFF;
               end else begin
                  next_state = ST_WAIT_ON;
               end
            end
         end
         ST_WAIT_OFF: begin
            if (eval_inactive) begin
               next_state = ST_WAIT_ON;
            end
         end
         ST_WAIT_ON: begin
            if (eval_active) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (cls_hand && !eval_active) begin
               next_state = ST_WAIT_ON;
            end
         end
         default: begin
            next_state = ST_STOP;
         end
      endcase
      if (!RUN_I) begin
         next_state = ST_STOP;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         scan_cnt <= SCAN_CNT_ZERO;
      end else if (scan_end) begin
         scan_cnt <= SCAN_CNT_ZERO;
      end else begin
         scan_cnt <= scan_cnt + SCAN_CNT_ONE;
      end
   end

   // Configuration is refused whole when any field is out of range, so a
   // half-applied setting can never reach the evaluation.
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         in_type <= TYPE_DEF;
         disc_set <= DISC_DEF_SET;
         cfg_err <= 1'b0;
      end else if (CFG_LOAD_I) begin
         cfg_err <= ~cfg_ok;
         if (cfg_ok) begin
            in_type <= CFG_TYPE_I;
            disc_set <= CFG_DISC_I;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state <= ST_STOP;
         running <= 1'b0;
      end else if (tick) begin
         state <= next_state;
         running <= RUN_I;
      end
   end

   // At startup the count is masked in the start scan, while running is still low, so an
   // input that is already on yields no count.
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         prev_active <= 1'b0;
         count_pulse <= 1'b0;
      end else if (tick) begin
         prev_active <= eval_active;
         count_pulse <= cls_count & running & RUN_I & ~start & rise &
                        ~any_err;
      end else begin
         count_pulse <= 1'b0;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         permit <= 1'b0;
         disc_err <= 1'b0;
         fault <= 1'b0;
      end else if (tick) begin
         permit <= next_permit | (start & next_state == ST_RUN &
                   eval_active);
         disc_err <= any_err;
         fault <= any_err;
      end
   end

   assign PERMIT_O = permit;
   assign DISC_ERR_O = disc_err;
   assign FAULT_O = fault;
   assign COUNT_O = count_pulse;
   assign ACTIVE_O = prev_active;
   assign ARMED_O = (state == ST_RUN);
   assign CFG_ERR_O = cfg_err;
   assign SCAN_O = tick;
endmodule

// ---- sim/sice_contacts.sv ----
// Model of the safety contacts wired to the evaluator inputs.
`timescale 1ns/1ps
module sice_contacts (
   input wire logic [3:0] want_i,
   output logic [3:0] in_o
);
   // Contacts settle 1 ns after the bench moves them, clear of clock edges.
   assign #1 in_o = want_i;
endmodule

// ---- sim/sice_eval_monitor.sv ----
// Concurrent checks on the ports of the evaluator.
`timescale 1ns/1ps
module sice_eval_monitor (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic RUN_I,
   input wire logic CFG_LOAD_I,
   input wire logic PERMIT_O,
   input wire logic DISC_ERR_O,
   input wire logic FAULT_O,
   input wire logic COUNT_O,
   input wire logic ACTIVE_O,
   input wire logic ARMED_O,
   input wire logic CFG_ERR_O,
   input wire logic SCAN_O
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   property p_permit_tick;
      $changed(PERMIT_O) |-> $past(SCAN_O);
   endproperty
   a_permit_tick: assert property (p_permit_tick)
      else $error("permit moved off a scan tick");
   property p_err_tick;
      $changed(DISC_ERR_O) |-> $past(SCAN_O);
   endproperty
   a_err_tick: assert property (p_err_tick)
      else $error("discrepancy flag moved off a scan tick");
   property p_fault;
      DISC_ERR_O |-> FAULT_O && !PERMIT_O;
   endproperty
   a_fault: assert property (p_fault)
      else $error("discrepancy without fault or with permit");
   property p_stop;
      SCAN_O && !RUN_I |=> !PERMIT_O && !ARMED_O;
   endproperty
   a_stop: assert property (p_stop)
      else $error("permit kept while stopped");
   property p_count;
      COUNT_O |-> $past(SCAN_O) && ACTIVE_O;
   endproperty
   a_count: assert property (p_count)
      else $error("count pulse without active status after tick");
   property p_cfg;
      $changed(CFG_ERR_O) |-> $past(CFG_LOAD_I);
   endproperty
   a_cfg: assert property (p_cfg)
      else $error("load flag changed without a load");
   property p_scan;
      SCAN_O |=> !SCAN_O [*8];
   endproperty
   a_scan: assert property (p_scan)
      else $error("scan ticks too close");
   property p_active;
      PERMIT_O |-> ACTIVE_O;
   endproperty
   a_active: assert property (p_active)
      else $error("permit without active status");
endmodule
bind sice_eval sice_eval_monitor u_mon (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
   .RUN_I(RUN_I), .CFG_LOAD_I(CFG_LOAD_I), .PERMIT_O(PERMIT_O),
   .DISC_ERR_O(DISC_ERR_O), .FAULT_O(FAULT_O), .COUNT_O(COUNT_O),
   .ACTIVE_O(ACTIVE_O), .ARMED_O(ARMED_O), .CFG_ERR_O(CFG_ERR_O),
   .SCAN_O(SCAN_O));

// ---- sim/tb_top.sv ----
// Self-checking testbench of the safety input channel evaluator.
`timescale 1ns/1ps
module tb_top;
   import sice_pkg::*;
   logic clk, rst_n, run, load, ftest;
   logic [2:0] ctype;
   logic [DISC_W-1:0] cdisc;
   logic [1:0] cls;
   logic [3:0] want, contacts;
   logic permit, derr, fault, cnt, act, armed, cerr, scan;
   int n_mismatch = 0;
   int cmp_count = 0;
   int n_pulse = 0;
   sice_contacts u_contacts (.want_i(want), .in_o(contacts));
   // A short scan keeps the 30 ms discrepancy run to a few hundred clocks.
   sice_eval #(.SCAN_CLKS(10)) dut (.CLK_I(clk), .RST_N_I(rst_n),
      .RUN_I(run), .CFG_LOAD_I(load), .CFG_TYPE_I(ctype),
      .CFG_DISC_I(cdisc), .CLASS_I(cls), .FUNC_TEST_I(ftest),
      .IN_I(contacts), .PERMIT_O(permit), .DISC_ERR_O(derr),
      .FAULT_O(fault), .COUNT_O(cnt), .ACTIVE_O(act), .ARMED_O(armed),
      .CFG_ERR_O(cerr), .SCAN_O(scan));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) if (cnt === 1'b1) n_pulse++;
   task automatic check(input logic seen, input logic exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Holds the contacts across one tick, then waits for the outputs.
   task automatic step(input logic [3:0] w);
      int k;
      want = w;
      k = 0;
      @(negedge clk);
      while (scan !== 1'b1 && k < 40) begin
         @(negedge clk);
         k++;
      end
      if (k >= 40) n_mismatch++;
      repeat (3) @(negedge clk);
   endtask
   // Every time set here is at least one scan, except the DISC_OFF_SET zero that t_truth uses to switch the check off.
   task automatic cfg(input logic [2:0] t, input logic [DISC_W-1:0] d);
      ctype = t;
      cdisc = d;
      load = 1'b1;
      @(negedge clk);
      load = 1'b0;
      @(negedge clk);
   endtask
   task automatic start(input logic [1:0] c, input logic [3:0] w);
      run = 1'b0;
      step(w);
      cls = c;
      run = 1'b1;
      step(w);
   endtask
   function automatic logic exp_permit(input logic [2:0] t,
                                       input logic [3:0] v);
      case (t)
         TYPE_SINGLE: return v[0];
         TYPE_DUAL_EQ: return v[1:0] == 2'h3;
         TYPE_DUAL_CO: return v[1:0] == 2'h1;
         TYPE_DUAL_EQ2: return v == 4'hF;
         default: return v == 4'h5;
      endcase
   endfunction
   task automatic t_cfg();
      int t;
      check(cerr, 1'b0);
      check(permit, 1'b0);
      for (t = 0; t < 6; t++) begin
         cfg(3'(t), 12'h003);
         check(cerr, t > 4);
      end
      cfg(TYPE_DUAL_EQ, 12'hBB8);
      check(cerr, 1'b0);
      cfg(TYPE_DUAL_EQ, 12'hBB9);
      check(cerr, 1'b1);
      $display("t_cfg done");
   endtask
   task automatic t_truth();
      int t, v;
      for (t = 0; t < 5; t++) begin
         cfg(3'(t), DISC_OFF_SET);
         start(CLASS_MONITOR, 4'h0);
         for (v = 0; v < 16; v++) begin
            step(4'(v));
            check(permit, exp_permit(3'(t), 4'(v)));
            check(derr, 1'b0);
         end
      end
      $display("t_truth done");
   endtask
   task automatic t_disc();
      cfg(TYPE_DUAL_EQ, DISC_DEF_SET);
      start(CLASS_MONITOR, 4'h3);
      check(permit, 1'b1);
      repeat (30) step(4'h2);
      check(derr, 1'b0);
      repeat (10) step(4'h2);
      check(derr, 1'b1);
      check(fault, 1'b1);
      step(4'h3);
      step(4'h0);
      check(derr, 1'b0);
      step(4'h3);
      repeat (30) step(4'h2);
      step(4'h3);
      check(derr, 1'b0);
      check(permit, 1'b1);
      repeat (40) step(4'h1);
      check(derr, 1'b1);
      start(CLASS_MONITOR, 4'h3);
      check(derr, 1'b0);
      check(permit, 1'b1);
      $display("t_disc done");
   endtask
   task automatic t_class();
      cfg(TYPE_DUAL_EQ, DISC_DEF_SET);
      n_pulse = 0;
      start(CLASS_COUNT, 4'h3);
      check(n_pulse == 0, 1'b1);
      step(4'h0);
      step(4'h3);
      check(n_pulse == 1, 1'b1);
      start(CLASS_TWOHAND, 4'h3);
      check(permit, 1'b0);
      step(4'h0);
      step(4'h3);
      check(permit, 1'b1);
      ftest = 1'b1;
      start(CLASS_GATE, 4'h3);
      check(permit, 1'b0);
      step(4'h0);
      step(4'h3);
      check(permit, 1'b1);
      ftest = 1'b0;
      start(CLASS_GATE, 4'h3);
      check(permit, 1'b1);
      $display("t_class done");
   endtask
   initial begin
      rst_n = 1'b0;
      run = 1'b0;
      load = 1'b0;
      ftest = 1'b0;
      ctype = TYPE_DEF;
      cdisc = DISC_DEF_SET;
      cls = CLASS_MONITOR;
      want = 4'h0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      t_cfg();
      t_truth();
      t_disc();
      t_class();
      tally_and_finish();
   end
   // The tests need about 2,250 clocks; the limit leaves wide margin.
   initial begin
      #250000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule
